// ### core/xor_skip_and_stack_ops_decode.sv
// Instruction decode and execute unit with AXI4-Lite register access
// Behaviour
// - Zero test discards next instruction, executes NOP
// - Test-skip: 1 cycle, 2 skipping, 3 over two-word
// - Access bit 0 access bank, 1 bank select
// - Extended, access bit 0, f<=5Fh: indexed offset
// - Literal XOR into work register, sets N Z
// - Register XOR, destination bit picks target, N Z
// - Extended group adds eight instructions, indexed addressing
// - Extension enable bit, enabled when unprogrammed
// - Pointer add/subtract 6-bit literal, one cycle, no flags
// - Special pointer forms use third pointer, return
// - Select 11 add: third pointer, return, 2 cycles
// - Select 11 subtract: third pointer, return, 2 cycles
// - Call through work register, 2 cycles, no flags
// - Push literal at third pointer, then decrement
//
// Local design decisions: the AXI4-Lite slave port and the placing of the registers.
module xor_skip_and_stack_ops_decode
   import xor_skip_and_stack_ops_decode_pkg::*;
#(
   parameter int STACK_DEPTH = 8
) (
   input wire logic clock,
   input wire logic nrst,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp
);
   localparam int SP_W = $clog2(STACK_DEPTH);

   exec_state_t state_q;
   logic [3:0] cnt_q;
   logic ext_q;
   logic [15:0] instr_q;
   logic [15:0] next_q;
   logic [7:0] work_q;
   logic z_q, n_q, skip_q, ill_q;
   logic [3:0] bank_q;
   logic [11:0] ptr_q [3];
   logic [15:0] pc_q;
   logic [11:0] maddr_q;
   logic [1:0] cyc_q;
   logic [7:0] mem [4096];
   logic [15:0] stk [STACK_DEPTH];
   logic [SP_W-1:0] sp_q;

   logic aw_held_q, w_held_q;
   logic [7:0] waddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   // Register read mux, bit 32 flags an unmapped address
   function automatic logic [32:0] reg_read(input logic [7:0] a);
      logic [32:0] r;
      r = '0;
      case ({a[7:2], 2'h0})
         ADDR_CTRL: r[CTRL_EXT_BIT] = ext_q;
         ADDR_INSTR: r[15:0] = instr_q;
         ADDR_NEXT: r[15:0] = next_q;
         ADDR_WORK: r[7:0] = work_q;
         ADDR_STATUS: begin
            r[ST_Z] = z_q;
            r[ST_N] = n_q;
            r[ST_BUSY] = (state_q == ST_RUN);
            r[ST_SKIP] = skip_q;
            r[ST_ILLEGAL] = ill_q;
         end
         ADDR_BANK: r[3:0] = bank_q;
         ADDR_PTR0: r[11:0] = ptr_q[0];
         ADDR_PTR1: r[11:0] = ptr_q[1];
         ADDR_PTR2: r[11:0] = ptr_q[2];
         ADDR_PC: r[15:0] = pc_q;
         ADDR_TOS: r[15:0] = stk[sp_q - SP_W'(1)];
         ADDR_MADDR: r[11:0] = maddr_q;
         ADDR_MDATA: r[7:0] = mem[maddr_q];
         ADDR_CYCLES: r[1:0] = cyc_q;
         default: r[32] = 1'b1;
      endcase
      return r;
   endfunction : reg_read

   // Operand address from the 8-bit field and access bit
   function automatic logic [11:0] eff_addr(input logic [7:0] f, input logic a);
      if (a) begin
         return {bank_q, f};
      end else if (f <= ACCESS_LIMIT) begin
         // Indexing only when the extension is on
         return ext_q ? ptr_q[2] + {4'h0, f} : {ACCESS_LOW_BANK, f};
      end
      return {ACCESS_HIGH_BANK, f};
   endfunction : eff_addr

   // First words that own a second program word
   function automatic logic two_word(input logic [15:0] w);
      return (w[15:9] == OP_CALL_ABS) || (w[15:8] == OP_LOAD_PTR) ||
         (w[15:8] == OP_GOTO_ABS) || (w[15:12] == OP_MOVE_REG) ||
         (ext_q && w[15:8] == OP_MOVE_OFS);
   endfunction : two_word

   // Bus write merge and fire
   logic wr_fire, wr_err, busy, go;
   logic [31:0] wval;
   logic [32:0] wold;
   always_comb begin
      wold = reg_read(waddr_q);
      for (int i = 0; i < 4; i++) begin
         wval[i*8 +: 8] = wstrb_q[i] ? wdata_q[i*8 +: 8] : wold[i*8 +: 8];
      end
   end
   assign busy = (state_q == ST_RUN);
   assign wr_fire = aw_held_q && w_held_q && !bvalid;
   // Writes during execution are refused, as are read-only and unmapped slots
   assign wr_err = wold[32] || busy || ({waddr_q[7:2], 2'h0} == ADDR_STATUS) ||
      ({waddr_q[7:2], 2'h0} == ADDR_PC) || ({waddr_q[7:2], 2'h0} == ADDR_TOS) ||
      ({waddr_q[7:2], 2'h0} == ADDR_CYCLES);
   assign go = wr_fire && !wr_err && ({waddr_q[7:2], 2'h0} == ADDR_INSTR);

   // Instruction decode, evaluated on the issued word
   logic [15:0] ins;
   logic [11:0] ea, src_a;
   logic [7:0] opnd, res, w_d, mem_wd;
   logic [11:0] mem_wa;
   logic [11:0] p_d [3];
   logic [15:0] pc_d;
   logic [1:0] cyc_d, sel;
   logic [5:0] k6;
   logic z_d, n_d, mem_we, push, pop, ill_d, skip_d;
   always_comb begin
      ins = wval[15:0];
      ea = eff_addr(ins[7:0], ins[8]);
      opnd = mem[ea];
      k6 = ins[5:0];
      sel = ins[7:6];
      src_a = ptr_q[2] + {5'h00, ins[6:0]};
      res = work_q ^ opnd;
      w_d = work_q;
      z_d = z_q;
      n_d = n_q;
      p_d = ptr_q;
      pc_d = pc_q + 16'h0001;
      mem_we = 1'b0;
      mem_wa = ea;
      mem_wd = res;
      push = 1'b0;
      pop = 1'b0;
      cyc_d = 2'h1;
      ill_d = 1'b0;
      skip_d = 1'b0;
      if (ins[15:9] == OP_TEST_SKIP) begin
         if (opnd == 8'h00) begin
            // Fetched next word becomes a NOP
            skip_d = 1'b1;
            cyc_d = two_word(next_q) ? 2'h3 : 2'h2;
            pc_d = two_word(next_q) ? pc_q + 16'h0003 : pc_q + 16'h0002;
         end
      end else if (ins[15:8] == OP_XOR_LIT) begin
         res = work_q ^ ins[7:0];
         w_d = res;
         z_d = (res == 8'h00);
         n_d = res[7];
      end else if (ins[15:10] == OP_XOR_REG) begin
         mem_we = ins[9];
         w_d = ins[9] ? work_q : res;
         z_d = (res == 8'h00);
         n_d = res[7];
      end else if (ext_q && ins == OP_CALL_WORK) begin
         push = 1'b1;
         pc_d = {pc_q[15:8], work_q};
         cyc_d = 2'h2;
      end else if (ext_q && (ins[15:8] == OP_PTR_ADD || ins[15:8] == OP_PTR_SUB)) begin
         if (sel == STACK_PTR_SEL) begin
            // Third pointer then return from subroutine
            p_d[2] = ins[8] ? ptr_q[2] - {6'h00, k6} : ptr_q[2] + {6'h00, k6};
            pop = 1'b1;
            cyc_d = 2'h2;
         end else begin
            p_d[sel] = ins[8] ? ptr_q[sel] - {6'h00, k6} : ptr_q[sel] + {6'h00, k6};
         end
      end else if (ext_q && ins[15:8] == OP_PUSH_LIT) begin
         mem_we = 1'b1;
         mem_wa = ptr_q[2];
         mem_wd = ins[7:0];
         p_d[2] = ptr_q[2] - 12'h001;
      end else if (ext_q && ins[15:8] == OP_MOVE_OFS && next_q[15:12] == SECOND_WORD_TAG) begin
         mem_we = 1'b1;
         mem_wa = ins[7] ? ptr_q[2] + {5'h00, next_q[6:0]} : next_q[11:0];
         mem_wd = mem[src_a];
         cyc_d = 2'h2;
         pc_d = pc_q + 16'h0002;
      end else begin
         // Unknown, or an extended opcode with the extension off
         ill_d = 1'b1;
      end
   end

   // Execution sequencer, four clocks per instruction cycle
   always_ff @(posedge clock) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
         cnt_q <= 4'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               if (go) begin
                  state_q <= ST_RUN;
                  cnt_q <= {cyc_d, 2'h0} - 4'h1;
               end
            end
            ST_RUN: begin
               cnt_q <= cnt_q - 4'h1;
               if (cnt_q == 4'h0) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // Architectural state: executed result wins, else bus write
   always_ff @(posedge clock) begin
      if (!nrst) begin
         ext_q <= EXT_RESET;
         instr_q <= 16'h0000;
         next_q <= 16'h0000;
         work_q <= 8'h00;
         z_q <= 1'b0;
         n_q <= 1'b0;
         skip_q <= 1'b0;
         ill_q <= 1'b0;
         bank_q <= 4'h0;
         ptr_q <= '{default: 12'h000};
         pc_q <= 16'h0000;
         maddr_q <= 12'h000;
         cyc_q <= 2'h0;
         sp_q <= '0;
      end else if (go) begin
         instr_q <= ins;
         work_q <= w_d;
         z_q <= z_d;
         n_q <= n_d;
         skip_q <= skip_d;
         ill_q <= ill_d;
         ptr_q <= p_d;
         pc_q <= pop ? stk[sp_q - SP_W'(1)] : pc_d;
         cyc_q <= cyc_d;
         if (push) begin
            sp_q <= sp_q + SP_W'(1);
         end else if (pop) begin
            sp_q <= sp_q - SP_W'(1);
         end
      end else if (wr_fire && !wr_err) begin
         case ({waddr_q[7:2], 2'h0})
            ADDR_CTRL: ext_q <= wval[CTRL_EXT_BIT];
            ADDR_NEXT: next_q <= wval[15:0];
            ADDR_WORK: work_q <= wval[7:0];
            ADDR_BANK: bank_q <= wval[3:0];
            ADDR_PTR0: ptr_q[0] <= wval[11:0];
            ADDR_PTR1: ptr_q[1] <= wval[11:0];
            ADDR_PTR2: ptr_q[2] <= wval[11:0];
            ADDR_MADDR: maddr_q <= wval[11:0];
            default: ;
         endcase
      end
   end

   // Data memory and return stack contents
   always_ff @(posedge clock) begin
      if (go && mem_we) begin
         mem[mem_wa] <= mem_wd;
      end else if (wr_fire && !wr_err && {waddr_q[7:2], 2'h0} == ADDR_MDATA) begin
         mem[maddr_q] <= wval[7:0];
      end
      if (go && push) begin
         stk[sp_q] <= pc_q + 16'h0001;
      end
   end

   // AXI4-Lite write channels, address and data taken in either order
   always_ff @(posedge clock) begin
      if (!nrst) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awready <= 1'b0;
         wready <= 1'b0;
         waddr_q <= 8'h00;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
         bvalid <= 1'b0;
         bresp <= RESP_OKAY;
      end else begin
         awready <= !aw_held_q && !(awvalid && awready);
         wready <= !w_held_q && !(wvalid && wready);
         if (awvalid && awready) begin
            aw_held_q <= 1'b1;
            waddr_q <= awaddr;
         end
         if (wvalid && wready) begin
            w_held_q <= 1'b1;
            wdata_q <= wdata;
            wstrb_q <= wstrb;
         end
         if (wr_fire) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // AXI4-Lite read channels
   logic [32:0] rd_val;
   assign rd_val = reg_read(araddr);
   always_ff @(posedge clock) begin
      if (!nrst) begin
         arready <= 1'b0;
         rvalid <= 1'b0;
         rdata <= 32'h0000_0000;
         rresp <= RESP_OKAY;
      end else if (arvalid && arready) begin
         arready <= 1'b0;
         rvalid <= 1'b1;
         rdata <= rd_val[31:0];
         rresp <= rd_val[32] ? RESP_SLVERR : RESP_OKAY;
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end else begin
         arready <= !rvalid;
      end
   end
endmodule : xor_skip_and_stack_ops_decode

// ### inc/xor_skip_and_stack_ops_decode_pkg.sv
// Constants for the exclusive-OR, skip and software-stack instruction unit
package xor_skip_and_stack_ops_decode_pkg;
   // Register byte addresses on the AXI4-Lite slave
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_INSTR = 8'h04;
   localparam logic [7:0] ADDR_NEXT = 8'h08;
   localparam logic [7:0] ADDR_WORK = 8'h0C;
   localparam logic [7:0] ADDR_STATUS = 8'h10;
   localparam logic [7:0] ADDR_BANK = 8'h14;
   localparam logic [7:0] ADDR_PTR0 = 8'h18;
   localparam logic [7:0] ADDR_PTR1 = 8'h1C;
   localparam logic [7:0] ADDR_PTR2 = 8'h20;
   localparam logic [7:0] ADDR_PC = 8'h24;
   localparam logic [7:0] ADDR_TOS = 8'h28;
   localparam logic [7:0] ADDR_MADDR = 8'h2C;
   localparam logic [7:0] ADDR_MDATA = 8'h30;
   localparam logic [7:0] ADDR_CYCLES = 8'h34;
   // Field positions and reset values
   localparam int CTRL_EXT_BIT = 0;
   localparam logic EXT_RESET = 1'b1;
   localparam int ST_Z = 0;
   localparam int ST_N = 2;
   localparam int ST_BUSY = 8;
   localparam int ST_SKIP = 9;
   localparam int ST_ILLEGAL = 10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Opcode fields
   localparam logic [6:0] OP_TEST_SKIP = 7'h33;
   localparam logic [7:0] OP_XOR_LIT = 8'h0A;
   localparam logic [5:0] OP_XOR_REG = 6'h06;
   localparam logic [15:0] OP_CALL_WORK = 16'h0014;
   localparam logic [7:0] OP_PTR_ADD = 8'hE8;
   localparam logic [7:0] OP_PTR_SUB = 8'hE9;
   localparam logic [7:0] OP_PUSH_LIT = 8'hEA;
   localparam logic [7:0] OP_MOVE_OFS = 8'hEB;
   localparam logic [6:0] OP_CALL_ABS = 7'h76;
   localparam logic [7:0] OP_LOAD_PTR = 8'hEE;
   localparam logic [7:0] OP_GOTO_ABS = 8'hEF;
   localparam logic [3:0] OP_MOVE_REG = 4'hC;
   localparam logic [3:0] SECOND_WORD_TAG = 4'hF;
   localparam logic [1:0] STACK_PTR_SEL = 2'h3;
   // Addressing
   localparam logic [7:0] ACCESS_LIMIT = 8'h5F;
   localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
   localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
   // Timing: clocks per instruction cycle (Q1..Q4)
   localparam int Q_PER_CYCLE = 4;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_RUN = 2'b10
   } exec_state_t;
endpackage : xor_skip_and_stack_ops_decode_pkg

// ### tb/xor_skip_and_stack_ops_decode_assertions.sv
// Register-port protocol checker for the instruction unit
module xor_skip_and_stack_ops_decode_assertions
   import xor_skip_and_stack_ops_decode_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic [1:0] bresp,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);

   AST_READY_AFTER_RESET: assert property (!$past(nrst) |-> !awready && !wready && !arready)
      else $error("ready high at first edge after reset");
   AST_AW_TAKEN: assert property (awvalid && awready |=> !awready)
      else $error("awready stayed high after address taken");
   AST_W_TAKEN: assert property (wvalid && wready |=> !wready)
      else $error("wready stayed high after data taken");
   // Slots are registered first, so the response shows one edge after the write fires
   AST_B_ANSWER: assert property (awvalid && awready && wvalid && wready && !bvalid |-> ##2 bvalid)
      else $error("no write response two cycles after both taken");
   AST_B_STANDS: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped or changed before bready");
   AST_B_RELEASE: assert property (bvalid && bready |=> !bvalid)
      else $error("bvalid held after bready");
   AST_R_ANSWER: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer not one cycle after address");
   AST_R_STANDS: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
      else $error("read answer dropped or changed before rready");
   AST_R_ERR_ZERO: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
      else $error("error read returned nonzero data");
   AST_AR_RETURN: assert property (rvalid && rready |=> !rvalid ##1 arready)
      else $error("arready not back one cycle after read ends");

   cover property (awvalid && awready && wvalid && wready);
   cover property (bvalid && bresp == RESP_SLVERR);
   cover property (rvalid && rresp == RESP_SLVERR);
endmodule : xor_skip_and_stack_ops_decode_assertions

bind xor_skip_and_stack_ops_decode xor_skip_and_stack_ops_decode_assertions u_chk (
   .clock(clock), .nrst(nrst), .awvalid(awvalid), .awready(awready), .wvalid(wvalid),
   .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
   .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
);

// ### tb/tb_xor_skip_and_stack_ops_decode.sv
// Table-driven testbench for the instruction unit
module tb_xor_skip_and_stack_ops_decode;
   timeunit 1ns;
   timeprecision 1ns;
   import xor_skip_and_stack_ops_decode_pkg::*;
   logic clock, nrst, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   int fails, total_checks;
   typedef struct {logic e; logic [15:0] op; logic [15:0] nx; logic [7:0] a;
      logic [31:0] m; logic [31:0] v; logic [31:0] c;} row_t;
   // Fixed starting state written before every row
   localparam logic [7:0] SA[8] = '{ADDR_WORK, ADDR_BANK, ADDR_PTR0, ADDR_PTR2,
      ADDR_MADDR, ADDR_MDATA, ADDR_MADDR, ADDR_MDATA};
   localparam logic [31:0] SD[8] = '{32'hB5, 32'h2, 32'h3FF, 32'h29F,
      32'h2B0, 32'h0, 32'h2AF, 32'hAF};
   row_t rows[21] = '{
      '{1'b1, 16'h0AAF, 16'h0, ADDR_WORK, 32'hFF, 32'h1A, 32'h1},
      '{1'b1, 16'h0AB5, 16'h0, ADDR_STATUS, 32'h5, 32'h1, 32'h1},
      '{1'b1, 16'h0A00, 16'h0, ADDR_STATUS, 32'h5, 32'h4, 32'h1},
      '{1'b1, 16'h1BAF, 16'h0, ADDR_MDATA, 32'hFF, 32'h1A, 32'h1},
      '{1'b1, 16'h19AF, 16'h0, ADDR_WORK, 32'hFF, 32'h1A, 32'h1},
      '{1'b1, 16'h1810, 16'h0, ADDR_WORK, 32'hFF, 32'h1A, 32'h1},
      '{1'b0, 16'h1A10, 16'h0, ADDR_MDATA, 32'hFF, 32'hAF, 32'h1},
      '{1'b1, 16'h67AF, 16'h0, ADDR_CYCLES, 32'h3, 32'h1, 32'h1},
      '{1'b1, 16'h67B0, 16'h0, ADDR_CYCLES, 32'h3, 32'h2, 32'h2},
      '{1'b1, 16'h67B0, 16'hEF00, ADDR_CYCLES, 32'h3, 32'h3, 32'h3},
      '{1'b1, 16'h67B0, 16'hEB00, ADDR_CYCLES, 32'h3, 32'h3, 32'h3},
      '{1'b0, 16'h67B0, 16'hEB00, ADDR_CYCLES, 32'h3, 32'h2, 32'h2},
      '{1'b1, 16'hE823, 16'h0, ADDR_PTR0, 32'hFFF, 32'h422, 32'h1},
      '{1'b1, 16'hE93F, 16'h0, ADDR_PTR0, 32'hFFF, 32'h3C0, 32'h1},
      '{1'b0, 16'hE823, 16'h0, ADDR_PTR0, 32'hFFF, 32'h3FF, 32'h1},
      '{1'b1, 16'hE8C5, 16'h0, ADDR_PTR2, 32'hFFF, 32'h2A4, 32'h2},
      '{1'b1, 16'hE9C5, 16'h0, ADDR_PTR2, 32'hFFF, 32'h29A, 32'h2},
      '{1'b1, 16'h0014, 16'h0, ADDR_PC, 32'hFF, 32'hB5, 32'h2},
      '{1'b1, 16'h67B0, 16'h0, ADDR_STATUS, 32'h200, 32'h200, 32'h2},
      '{1'b0, 16'hE823, 16'h0, ADDR_STATUS, 32'h400, 32'h400, 32'h1},
      '{1'b1, 16'hEB11, 16'hF2AF, ADDR_MDATA, 32'hFF, 32'h0, 32'h2}
   };

   xor_skip_and_stack_ops_decode uut (
      .clock(clock), .nrst(nrst), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp)
   );

   task automatic end_of_test();
      if (fails == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask : chk

   task automatic limit(input int n, input int mx);
      if (n >= mx) begin
         fails++;
         end_of_test();
      end
   endtask : limit

   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      int n;
      @(posedge clock);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= d;
      bready <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 200);
      bready <= 1'b0;
      limit(n, 200);
      chk("bresp", {30'h0, er}, {30'h0, bresp});
   endtask : wr

   task automatic cr(input string nm, input logic [7:0] a, input logic [31:0] m,
         input logic [31:0] e, output logic [31:0] d);
      int n;
      @(posedge clock);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      n = 0;
      do begin
         @(posedge clock);
         n++;
         if (arvalid && arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 200);
      d = rdata;
      chk("rresp", {30'h0, (a > ADDR_CYCLES) ? RESP_SLVERR : RESP_OKAY}, {30'h0, rresp});
      rready <= 1'b0;
      limit(n, 200);
      chk(nm, e, d & m);
   endtask : cr

   // Polls busy; a hung instruction ends the run
   task automatic exec(input logic e, input logic [15:0] op, input logic [15:0] nx);
      logic [31:0] d;
      int n;
      wr(ADDR_CTRL, {31'h0, e}, RESP_OKAY);
      for (int i = 0; i < 8; i++) begin
         wr(SA[i], SD[i], RESP_OKAY);
      end
      wr(ADDR_NEXT, {16'h0, nx}, RESP_OKAY);
      wr(ADDR_INSTR, {16'h0, op}, RESP_OKAY);
      n = 0;
      do begin
         cr("busy", ADDR_STATUS, 32'h0, 32'h0, d);
         n++;
      end while (d[ST_BUSY] !== 1'b0 && n < 50);
      limit(n, 50);
   endtask : exec

   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   initial begin
      logic [31:0] d;
      {nrst, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata} = '0;
      wstrb = 4'hF;
      fails = 0;
      total_checks = 0;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      foreach (rows[i]) begin
         exec(rows[i].e, rows[i].op, rows[i].nx);
         cr("result", rows[i].a, rows[i].m, rows[i].v, d);
         cr("cycles", ADDR_CYCLES, 32'h3, rows[i].c, d);
      end
      exec(1'b1, 16'hEA5A, 16'h0);
      cr("ptr2", ADDR_PTR2, 32'hFFF, 32'h29E, d);
      wr(ADDR_MADDR, 32'h29F, RESP_OKAY);
      cr("pushed", ADDR_MDATA, 32'hFF, 32'h5A, d);
      exec(1'b1, 16'hEB91, 16'hF010);
      cr("move", ADDR_MDATA, 32'hFF, 32'h0, d);
      // Write during a two-cycle call must be refused
      wr(ADDR_INSTR, 32'h0014, RESP_OKAY);
      wr(ADDR_WORK, 32'h11, RESP_SLVERR);
      repeat (10) @(posedge clock);
      cr("work", ADDR_WORK, 32'hFF, 32'hB5, d);
      // Lane 0 strobe off keeps the old byte
      wstrb <= 4'hE;
      wr(ADDR_WORK, 32'h77, RESP_OKAY);
      wstrb <= 4'hF;
      cr("strobe", ADDR_WORK, 32'hFF, 32'hB5, d);
      wr(ADDR_STATUS, 32'h0, RESP_SLVERR);
      wr(8'h3C, 32'h1, RESP_SLVERR);
      cr("unmapped", 8'h3C, 32'hFFFFFFFF, 32'h0, d);
      // Clear the enable so the reset value is really seen
      wr(ADDR_CTRL, 32'h0, RESP_OKAY);
      @(posedge clock);
      nrst <= 1'b0;
      repeat (20) @(posedge clock);
      nrst <= 1'b1;
      cr("ctrl", ADDR_CTRL, 32'hFFFFFFFF, 32'h1, d);
      cr("work", ADDR_WORK, 32'hFFFFFFFF, 32'h0, d);
      end_of_test();
   end
endmodule : tb_xor_skip_and_stack_ops_decode
